// [tws_pkg.sv]
// Constants and register map of the two-wire slave with buffer DMA
package tws_pkg;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 14;
  localparam int N_ADDR = 2;
  localparam int N_EV = 3;
  // Register offsets
  localparam logic [11:0] OFS_TASKS = 12'h000;
  localparam logic [11:0] OFS_INT_STATUS = 12'h304;
  localparam logic [11:0] OFS_INT_MASK = 12'h308;
  localparam logic [11:0] OFS_MATCH = 12'h4d4;
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_RX_PTR = 12'h534;
  localparam logic [11:0] OFS_RX_MAX = 12'h538;
  localparam logic [11:0] OFS_RX_AMOUNT = 12'h53c;
  localparam logic [11:0] OFS_RX_LIST = 12'h540;
  localparam logic [11:0] OFS_TX_PTR = 12'h544;
  localparam logic [11:0] OFS_TX_MAX = 12'h548;
  localparam logic [11:0] OFS_TX_AMOUNT = 12'h54c;
  localparam logic [11:0] OFS_TX_LIST = 12'h550;
  localparam logic [11:0] OFS_SADDR_BASE = 12'h588;
  localparam logic [11:0] OFS_SADDR_STEP = 12'h004;
  localparam logic [11:0] OFS_SADDR1 = OFS_SADDR_BASE + OFS_SADDR_STEP;
  localparam logic [11:0] OFS_CONFIG = 12'h594;
  localparam logic [11:0] OFS_ORC = 12'h5c0;
  // Field positions
  localparam int TASK_PREP_RX = 0;
  localparam int TASK_PREP_TX = 1;
  localparam int EV_STOPPED = 0;
  localparam int EV_WRITE = 1;
  localparam int EV_READ = 2;
  // Reset values
  localparam logic [1:0] RST_CONFIG = 2'h1;
  localparam logic [7:0] RST_ORC = 8'h00;
  localparam logic [31:0] RST_PTR = 32'h0000_0000;
  localparam logic [CNT_W-1:0] RST_CNT = 14'h0000;
  // Prepare latency: 1.5 us at 125 MHz, rounded down
  localparam int PREP_TIME_NS = 1500;
  localparam int CLK_MHZ = 125;
  localparam logic [7:0] PREP_CYC = 8'(PREP_TIME_NS * CLK_MHZ / 1000);
endpackage

// [tws_dma.sv]
// Single-byte memory master used by both buffer channels
`timescale 1ns/1ps
`default_nettype none
module tws_dma (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic done,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 8'h00;
      rdata <= 8'h00;
      done <= 1'b0;
    end else if (mem_req && mem_ack) begin
      mem_req <= 1'b0;
      done <= 1'b1;
      rdata <= mem_rdata;
    end else begin
      done <= 1'b0;
      // A request while busy is dropped; bus byte times are far longer
      if (go && !mem_req) begin
        mem_req <= 1'b1;
        mem_we <= we;
        mem_addr <= addr;
        mem_wdata <= wdata;
      end
    end
  end
endmodule
`default_nettype wire

// [tws_link.sv]
// Bit engine of the two-wire slave: start/stop, byte shift, acknowledge, stretch
`timescale 1ns/1ps
`default_nettype none
module tws_link (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] shreg,
  output logic addr_stb,
  input wire logic addr_ack,
  output logic rx_stb,
  output logic tx_need,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic start_stb,
  output logic stop_stb
);
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_WDATA, S_WACK, S_LOAD, S_RDATA, S_RACK
  } tws_link_e;
  tws_link_e state;
  logic scl_q;
  logic sda_q;
  logic [2:0] bitn;
  logic ack_hold;
  logic scl_hold;
  logic ackph;
  logic mack;
  logic rise;
  logic fall;
  logic start_cond;
  logic stop_cond;

  assign rise = scl_in & ~scl_q;
  assign fall = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond = scl_in & scl_q & ~sda_q & sda_in;
  // Clock is held low while a transmit byte is being fetched, and one cycle
  // longer so the first data bit is settled before the master can raise it
  assign scl_oe = (state == S_LOAD) | scl_hold;
  assign tx_need = (state == S_LOAD);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      start_stb <= 1'b0;
      stop_stb <= 1'b0;
      addr_stb <= 1'b0;
      rx_stb <= 1'b0;
      scl_hold <= 1'b0;
    end else begin
      scl_hold <= (state == S_LOAD) && tx_valid;
      scl_q <= scl_in;
      sda_q <= sda_in;
      start_stb <= start_cond;
      stop_stb <= stop_cond;
      addr_stb <= (state == S_ADDR) && rise && (bitn == 3'h7) && !start_cond;
      rx_stb <= (state == S_WDATA) && rise && (bitn == 3'h7) && !start_cond;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_IDLE;
      shreg <= 8'h00;
      bitn <= 3'h0;
      sda_oe <= 1'b0;
      ack_hold <= 1'b0;
      ackph <= 1'b0;
      mack <= 1'b0;
    end else if (start_cond) begin
      state <= S_ADDR;
      bitn <= 3'h0;
      sda_oe <= 1'b0;
      ackph <= 1'b0;
    end else if (stop_cond) begin
      state <= S_IDLE;
      sda_oe <= 1'b0;
      ackph <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          sda_oe <= 1'b0;
        end
        S_ADDR, S_WDATA: begin
          ack_hold <= 1'b1;
          if (rise) begin
            shreg <= {shreg[6:0], sda_in};
            bitn <= bitn + 3'h1;
            if (bitn == 3'h7) begin
              state <= (state == S_ADDR) ? S_AACK : S_WACK;
            end
          end
        end
        S_AACK, S_WACK: begin
          if (addr_stb) begin
            ack_hold <= addr_ack;
          end
          if (fall && !ackph) begin
            ackph <= 1'b1;
            sda_oe <= ack_hold;
            if (!ack_hold) begin
              state <= S_IDLE;
            end
          end else if (fall) begin
            ackph <= 1'b0;
            sda_oe <= 1'b0;
            bitn <= 3'h0;
            state <= (state == S_AACK && shreg[0]) ? S_LOAD : S_WDATA;
          end
        end
        S_LOAD: begin
          if (tx_valid) begin
            shreg <= tx_byte;
            sda_oe <= ~tx_byte[7];
            bitn <= 3'h0;
            state <= S_RDATA;
          end
        end
        S_RDATA: begin
          if (fall) begin
            if (bitn == 3'h7) begin
              sda_oe <= 1'b0;
              state <= S_RACK;
            end else begin
              sda_oe <= ~shreg[6];
              shreg <= {shreg[6:0], 1'b0};
              bitn <= bitn + 3'h1;
            end
          end
        end
        S_RACK: begin
          if (rise) begin
            mack <= ~sda_in;
          end
          if (fall) begin
            state <= mack ? S_LOAD : S_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [tws_top.sv]
// Two-wire slave with receive/transmit buffer DMA, address match and registers
//
// Behaviour
// (RL1) The receive transferred-count register shows the bytes written to memory in the last receive.
// (RL2) The transmit transferred-count register shows the bytes fetched and sent in the last transmit.
// (RL3) Received bytes beyond the receive maximum count are not stored.
// (RL4) At most the transmit maximum count of bytes is fetched per read transaction.
// (RL5) Bytes read beyond the transmit buffer are answered with the over-read filler.
// (RL6) Two slave addresses are compared with the incoming address, each enabled by config.
// (RL7) A prepare task makes its direction ready after the prepare latency.
// (RL8) The match status shows which slave address matched in the current transaction.
// (RL9) Each transferred count is updated when its transaction ends by stop or restart.
`timescale 1ns/1ps
`default_nettype none
module tws_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [tws_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic irq
);
  import tws_pkg::*;

  logic [31:0] rx_ptr;
  logic [CNT_W-1:0] rx_max;
  logic [CNT_W-1:0] rx_amount;
  logic rx_list;
  logic [31:0] tx_ptr;
  logic [CNT_W-1:0] tx_max;
  logic [CNT_W-1:0] tx_amount;
  logic tx_list;
  logic [6:0] saddr [N_ADDR];
  logic [N_ADDR-1:0] cfg;
  logic [7:0] over_read_filler;
  logic match_idx;
  logic enable;
  logic [N_EV-1:0] irq_mask;
  logic [N_EV-1:0] irq_stat;
  logic [N_EV-1:0] ev;
  logic act_rx;
  logic act_tx;
  logic [CNT_W-1:0] rx_cnt;
  logic [CNT_W-1:0] tx_cnt;
  logic [1:0] ready;
  logic [1:0] end_dir;
  logic tx_pend;
  logic [7:0] tx_byte;
  logic tx_valid;
  logic [7:0] shreg;
  logic addr_stb;
  logic addr_ack;
  logic rx_stb;
  logic tx_need;
  logic start_stb;
  logic stop_stb;
  logic hit;
  logic hit_idx;
  logic accept;
  logic trans_end;
  logic wr_go;
  logic rd_go;
  logic dma_done;
  logic [7:0] dma_rdata;
  logic [31:0] dma_addr;
  logic [31:0] rd_mux;

  // Open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  tws_link u_link (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe),
    .shreg(shreg),
    .addr_stb(addr_stb),
    .addr_ack(addr_ack),
    .rx_stb(rx_stb),
    .tx_need(tx_need),
    .tx_byte(tx_byte),
    .tx_valid(tx_valid),
    .start_stb(start_stb),
    .stop_stb(stop_stb)
  );

  tws_dma u_dma (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .go(wr_go | rd_go),
    .we(wr_go),
    .addr(dma_addr),
    .wdata(shreg),
    .rdata(dma_rdata),
    .done(dma_done),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack)
  );

  // Lowest enabled matching entry wins
  always_comb begin
    hit = 1'b0;
    hit_idx = 1'b0;
    for (int i = N_ADDR - 1; i >= 0; i--) begin
      if (cfg[i] && shreg[7:1] == saddr[i]) begin // RL6
        hit = 1'b1;
        hit_idx = i[0];
      end
    end
  end

  // Not prepared for the requested direction means no acknowledge
  assign addr_ack = enable & hit & (shreg[0] ? ready[1] : ready[0]); // RL6
  assign accept = addr_stb & addr_ack;
  assign trans_end = (stop_stb | start_stb) & (act_rx | act_tx);
  assign end_dir = {trans_end & act_tx, trans_end & act_rx};
  assign wr_go = rx_stb & act_rx & (rx_cnt < rx_max); // RL3
  assign rd_go = tx_need & act_tx & ~tx_pend & ~tx_valid & (tx_cnt < tx_max); // RL4
  assign dma_addr = act_tx ? tx_ptr + 32'(tx_cnt) : rx_ptr + 32'(rx_cnt);
  assign ev[EV_STOPPED] = stop_stb & (act_rx | act_tx);
  assign ev[EV_WRITE] = accept & ~shreg[0];
  assign ev[EV_READ] = accept & shreg[0];
  assign irq = |(irq_stat & irq_mask);

  // Transaction tracking and match status
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      act_rx <= 1'b0;
      act_tx <= 1'b0;
      match_idx <= 1'b0;
    end else if (accept) begin
      act_rx <= ~shreg[0];
      act_tx <= shreg[0];
      match_idx <= hit_idx; // RL8
    end else if (trans_end) begin
      act_rx <= 1'b0;
      act_tx <= 1'b0;
    end
  end

  // Receive channel: pointer, limit, live and latched counts
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_ptr <= RST_PTR;
      rx_max <= RST_CNT;
      rx_list <= 1'b0;
      rx_cnt <= RST_CNT;
      rx_amount <= RST_CNT;
    end else begin
      if (reg_wr && reg_addr == OFS_RX_PTR) begin
        rx_ptr <= reg_wdata;
      end else if (end_dir[0] && rx_list) begin
        rx_ptr <= rx_ptr + 32'(rx_max);
      end
      if (reg_wr && reg_addr == OFS_RX_MAX) begin
        rx_max <= reg_wdata[CNT_W-1:0];
      end
      if (reg_wr && reg_addr == OFS_RX_LIST) begin
        rx_list <= reg_wdata[0];
      end
      if (accept && !shreg[0]) begin
        rx_cnt <= RST_CNT;
      end else if (wr_go) begin
        rx_cnt <= rx_cnt + 14'h0001; // RL1
      end
      if (end_dir[0]) begin
        rx_amount <= rx_cnt; // RL9
      end
    end
  end

  // Transmit channel: fetch from memory or fall back to the filler
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_ptr <= RST_PTR;
      tx_max <= RST_CNT;
      tx_list <= 1'b0;
      tx_cnt <= RST_CNT;
      tx_amount <= RST_CNT;
      tx_pend <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == OFS_TX_PTR) begin
        tx_ptr <= reg_wdata;
      end else if (end_dir[1] && tx_list) begin
        tx_ptr <= tx_ptr + 32'(tx_max);
      end
      if (reg_wr && reg_addr == OFS_TX_MAX) begin
        tx_max <= reg_wdata[CNT_W-1:0];
      end
      if (reg_wr && reg_addr == OFS_TX_LIST) begin
        tx_list <= reg_wdata[0];
      end
      tx_valid <= 1'b0;
      if (accept && shreg[0]) begin
        tx_cnt <= RST_CNT;
        tx_pend <= 1'b0;
      end else if (rd_go) begin
        tx_cnt <= tx_cnt + 14'h0001; // RL2
        tx_pend <= 1'b1;
      end else if (tx_pend && dma_done) begin
        tx_pend <= 1'b0;
        tx_byte <= dma_rdata;
        tx_valid <= 1'b1;
      end else if (tx_need && act_tx && !tx_pend && !tx_valid) begin
        tx_byte <= over_read_filler; // RL5
        tx_valid <= 1'b1;
      end
      if (end_dir[1]) begin
        tx_amount <= tx_cnt; // RL9
      end
    end
  end

  // Prepare latency per direction; readiness is used up by one transaction
  for (genvar d = 0; d < 2; d++) begin : g_prep
    logic [7:0] prep_cnt;
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        prep_cnt <= 8'h00;
        ready[d] <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_TASKS && reg_wdata[d]) begin
        prep_cnt <= PREP_CYC; // RL7
        ready[d] <= 1'b0;
      end else if (prep_cnt != 8'h00) begin
        prep_cnt <= prep_cnt - 8'h01;
        ready[d] <= (prep_cnt == 8'h01); // RL7
      end else if (end_dir[d]) begin
        ready[d] <= 1'b0;
      end
    end
  end

  // Address entries, config, filler and enable
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      saddr[0] <= 7'h00;
      saddr[1] <= 7'h00;
      cfg <= RST_CONFIG;
      over_read_filler <= RST_ORC;
      enable <= 1'b0;
      irq_mask <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_SADDR_BASE: saddr[0] <= reg_wdata[6:0];
        OFS_SADDR1: saddr[1] <= reg_wdata[6:0];
        OFS_CONFIG: cfg <= reg_wdata[N_ADDR-1:0];
        OFS_ORC: over_read_filler <= reg_wdata[7:0];
        OFS_ENABLE: enable <= reg_wdata[0];
        OFS_INT_MASK: irq_mask <= reg_wdata[N_EV-1:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky events; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat <= '0;
    end else if (reg_wr && reg_addr == OFS_INT_STATUS) begin
      irq_stat <= (irq_stat & ~reg_wdata[N_EV-1:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      OFS_INT_STATUS: rd_mux = 32'(irq_stat);
      OFS_INT_MASK: rd_mux = 32'(irq_mask);
      OFS_MATCH: rd_mux = 32'(match_idx); // RL8
      OFS_ENABLE: rd_mux = 32'(enable);
      OFS_RX_PTR: rd_mux = rx_ptr;
      OFS_RX_MAX: rd_mux = 32'(rx_max);
      OFS_RX_AMOUNT: rd_mux = 32'(rx_amount); // RL1
      OFS_RX_LIST: rd_mux = 32'(rx_list);
      OFS_TX_PTR: rd_mux = tx_ptr;
      OFS_TX_MAX: rd_mux = 32'(tx_max);
      OFS_TX_AMOUNT: rd_mux = 32'(tx_amount); // RL2
      OFS_TX_LIST: rd_mux = 32'(tx_list);
      OFS_SADDR_BASE: rd_mux = 32'(saddr[0]);
      OFS_SADDR1: rd_mux = 32'(saddr[1]);
      OFS_CONFIG: rd_mux = 32'(cfg);
      OFS_ORC: rd_mux = 32'(over_read_filler);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// [tws_chk_sva.sv]
// Checker of the two-wire slave top: register reads, memory port and wire timing
`timescale 1ns/1ps
`default_nettype none
module tws_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [tws_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack
);
  import tws_pkg::*;
  logic [CNT_W-1:0] rx_max, tx_max, wcnt, rcnt, rx_snap, tx_snap;
  logic scl_q, sda_q, start, stop;
  assign start = scl_q && scl_in && sda_q && !sda_in;
  assign stop = scl_q && scl_in && !sda_q && sda_in;
  // Snapshots skip empty transactions so a refused address keeps the last count
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {scl_q, sda_q} <= 2'h3;
      {rx_max, tx_max, wcnt, rcnt, rx_snap, tx_snap} <= '0;
    end else begin
      {scl_q, sda_q} <= {scl_in, sda_in};
      if (reg_wr && reg_addr == OFS_RX_MAX) rx_max <= reg_wdata[CNT_W-1:0];
      if (reg_wr && reg_addr == OFS_TX_MAX) tx_max <= reg_wdata[CNT_W-1:0];
      if (mem_req && mem_ack && mem_we) wcnt <= wcnt + 1'b1;
      if (mem_req && mem_ack && !mem_we) rcnt <= rcnt + 1'b1;
      if ((start || stop) && wcnt != '0) rx_snap <= wcnt;
      if ((start || stop) && rcnt != '0) tx_snap <= rcnt;
      if (start) begin
        wcnt <= '0;
        rcnt <= '0;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_rx_cap;
    mem_req && mem_we |-> wcnt < rx_max;
  endproperty
  a_rx_cap: assert property (p_rx_cap) else $error("store past receive max");
  property p_tx_cap;
    mem_req && !mem_we |-> rcnt < tx_max;
  endproperty
  a_tx_cap: assert property (p_tx_cap) else $error("fetch past transmit max");
  property p_rx_amt;
    $past(reg_rd) && $past(reg_addr) == OFS_RX_AMOUNT |-> reg_rdata == 32'(rx_snap);
  endproperty
  a_rx_amt: assert property (p_rx_amt) else $error("receive count wrong");
  property p_tx_amt;
    $past(reg_rd) && $past(reg_addr) == OFS_TX_AMOUNT |-> reg_rdata == 32'(tx_snap);
  endproperty
  a_tx_amt: assert property (p_tx_amt) else $error("transmit count wrong");
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped");
  property p_sda_low;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in);
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data moved with clock high");
  property p_match;
    $past(reg_rd) && $past(reg_addr) == OFS_MATCH |-> reg_rdata[31:1] == '0;
  endproperty
  a_match: assert property (p_match) else $error("match status too wide");
  property p_rdata0;
    !$past(reg_rd) |-> reg_rdata == '0;
  endproperty
  a_rdata0: assert property (p_rdata0) else $error("read data outside slot");
  c_full: cover property (stop && wcnt == rx_max && rx_max != '0);
  c_fetch: cover property (mem_req && mem_ack && !mem_we);
  c_ack: cover property (sda_oe && scl_in);
endmodule
bind tws_top tws_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack));
`default_nettype wire

// [tws_master.sv]
// Behavioural two-wire bus master pulling the open-drain wires
`timescale 1ns/1ps
`default_nettype none
module tws_master (
  input wire logic mclk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_low,
  output logic sda_low
);
  int hp = 4;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Bounded wait on a stretched clock; a hung slave is left to the watchdog
  task automatic bit_io(input logic b, output logic r);
    int k;
    k = 0;
    sda_low <= !b;
    tick(hp);
    scl_low <= 1'b0;
    do begin
      @(negedge mclk);
      k++;
    end while (!scl_in && k < 5000);
    tick(hp);
    r = sda_in;
    scl_low <= 1'b1;
    tick(hp);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    tick(hp);
    scl_low <= 1'b0;
    tick(hp);
    sda_low <= 1'b1;
    tick(hp);
    scl_low <= 1'b1;
    tick(hp);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    tick(hp);
    scl_low <= 1'b0;
    tick(hp);
    sda_low <= 1'b0;
    tick(hp);
  endtask
  task automatic xfer(input logic [7:0] b, input logic mack, output logic [7:0] r,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(!mack, s);
    ack = !s;
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Bench for the two-wire slave: registers, store and fetch transfers, interrupt
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tws_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic mem_ack = 1'b0;
  logic [7:0] mem_rdata = '0;
  logic [31:0] reg_rdata, mem_addr;
  logic [7:0] mem_wdata;
  logic scl_out, scl_oe, sda_out, sda_oe, mem_req, mem_we, irq, m_scl, m_sda;
  logic [7:0] mem [256];
  int miscompares = 0;
  int num_checks = 0;
  int mdly = 0;
  int mw = 0;
  wire scl_w = (scl_oe ? scl_out : 1'b1) && !m_scl;
  wire sda_w = (sda_oe ? sda_out : 1'b1) && !m_sda;
  always #4 mclk = ~mclk;
  tws_top uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));
  tws_master u_m (.mclk(mclk), .scl_in(scl_w), .sda_in(sda_w), .scl_low(m_scl),
    .sda_low(m_sda));
  // Read data toggles outside the answer so a late sample cannot match
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      mw <= mw + 1;
      if (mw >= mdly) begin
        mw <= 0;
        mem_ack <= 1'b1;
        if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
        else mem_rdata <= mem[mem_addr[7:0]];
      end
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic t_regs();
    rchk(OFS_RX_AMOUNT, 32'h0);
    rchk(OFS_TX_AMOUNT, 32'h0);
    rchk(OFS_MATCH, 32'h0);
    rchk(OFS_CONFIG, 32'h1);
    wr(OFS_RX_AMOUNT, 32'hffff_ffff);
    rchk(OFS_RX_AMOUNT, 32'h0);
    wr(OFS_ORC, 32'h0000_01a5);
    rchk(OFS_ORC, 32'h0000_00a5);
    rchk(12'h7fc, 32'h0);
  endtask
  task automatic t_write();
    logic [7:0] r;
    logic a;
    mem[8'h42] = 8'hee;
    wr(OFS_ENABLE, 32'h1);
    wr(OFS_SADDR_BASE, 32'h21);
    wr(OFS_SADDR1, 32'h35);
    wr(OFS_CONFIG, 32'h3);
    wr(OFS_RX_PTR, 32'h40);
    wr(OFS_RX_MAX, 32'h2);
    wr(OFS_INT_MASK, 32'h1);
    wr(OFS_TASKS, 32'h1 << TASK_PREP_RX);
    u_m.start();
    u_m.xfer(8'h6a, 1'b0, r, a);
    chk(32'(a), 32'h0);
    u_m.stop();
    repeat (PREP_CYC) @(posedge mclk);
    u_m.start();
    u_m.xfer(8'h6a, 1'b0, r, a);
    chk(32'(a), 32'h1);
    for (int i = 1; i <= 3; i++) u_m.xfer(8'(i * 17), 1'b0, r, a);
    u_m.stop();
    repeat (4) @(posedge mclk);
    chk(32'(mem[8'h40]), 32'h11);
    chk(32'(mem[8'h41]), 32'h22);
    chk(32'(mem[8'h42]), 32'hee);
    rchk(OFS_RX_AMOUNT, 32'h2);
    rchk(OFS_MATCH, 32'h1);
    chk(32'(irq), 32'h1);
    wr(OFS_INT_STATUS, 32'h1);
    rchk(OFS_INT_STATUS, 32'h2);
    chk(32'(irq), 32'h0);
  endtask
  task automatic t_read();
    logic [7:0] e [4] = '{8'ha1, 8'hb2, 8'h5a, 8'h5a};
    logic [7:0] r;
    logic a;
    mem[8'h80] = 8'ha1;
    mem[8'h81] = 8'hb2;
    mem[8'h82] = 8'hc3;
    mdly = 3;
    u_m.hp = 6;
    wr(OFS_TX_PTR, 32'h80);
    wr(OFS_TX_MAX, 32'h2);
    wr(OFS_ORC, 32'h5a);
    wr(OFS_TASKS, 32'h1 << TASK_PREP_TX);
    repeat (PREP_CYC) @(posedge mclk);
    u_m.start();
    u_m.xfer(8'h43, 1'b0, r, a);
    chk(32'(a), 32'h1);
    for (int i = 0; i < 4; i++) begin
      u_m.xfer(8'hff, i < 3, r, a);
      chk(32'(r), 32'(e[i]));
    end
    u_m.stop();
    repeat (4) @(posedge mclk);
    rchk(OFS_TX_AMOUNT, 32'h2);
    rchk(OFS_MATCH, 32'h0);
    wr(OFS_CONFIG, 32'h1);
    wr(OFS_TASKS, 32'h1 << TASK_PREP_TX);
    repeat (PREP_CYC) @(posedge mclk);
    u_m.start();
    u_m.xfer(8'h6b, 1'b0, r, a);
    chk(32'(a), 32'h0);
    u_m.stop();
    repeat (4) @(posedge mclk);
    chk(32'({scl_oe, sda_oe, scl_out, sda_out}), 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_write();
    t_read();
    conclude();
  end
endmodule
`default_nettype wire
